// ==== design/iww_pkg.sv ====
// constants and carriers for the window watchdog
// assumes one system clock; oscillator arrives as a plain input
package iww_pkg;
	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_KEY = 8'h00;
	localparam logic [7:0] OFS_CFG = 8'h04;
	localparam logic [7:0] OFS_RLD = 8'h08;
	localparam logic [7:0] OFS_STAT = 8'h0C;
	localparam logic [7:0] OFS_WIN = 8'h10;
	localparam logic [7:0] OFS_CNT = 8'h24;
	// ----------------------------------------
	// key codes
	// ----------------------------------------
	localparam logic [15:0] KEY_START = 16'hCCCC;
	localparam logic [15:0] KEY_REFRESH = 16'hAAAA;
	localparam logic [15:0] KEY_UNLOCK = 16'h5555;
	localparam logic [15:0] KEY_STOP1 = 16'h5A5A;
	localparam logic [15:0] KEY_STOP2 = 16'hA5A5;
	// ----------------------------------------
	// counter and reset values
	// ----------------------------------------
	localparam int CNT_W = 12;
	localparam logic [11:0] CNT_START = 12'hFFF;
	localparam logic [11:0] RLD_RST = 12'hFFF;
	localparam logic [11:0] WIN_RST = 12'h0FFF;
	localparam logic [9:0] DIV_BASE = 10'h004;
	// ----------------------------------------
	// status bit positions
	// ----------------------------------------
	localparam int ST_RELOAD = 5;
	localparam int ST_RUN = 4;
	localparam int ST_OV = 3;
	localparam int ST_WINF = 2;
	localparam int ST_RLDF = 1;
	localparam int ST_CFGF = 0;
	localparam int CFG_W = 6;
	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic sleep_hold;
		logic irq_enable;
		logic resp_sel;
		logic [2:0] divider_select;
	} iww_cfg_t;
	localparam iww_cfg_t CFG_RST = 6'h00;
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} iww_bus_t;
endpackage

// ==== design/iww_top.sv ====
// window watchdog: key port, protected config, 12-bit down counter
// assumes i_osc is the slow oscillator, asynchronous to i_clk
`timescale 1ns/1ns
// What this block does
// [R1] twelve-bit reloadable down counter on prescaled oscillator
// [R2] prescaler divides oscillator by four to 512
// [R3] start key begins counting down from FFF
// [R4] refresh key loads reload value into counter
// [R5] a tick at zero flags overflow and reloads
// [R6] response select picks reset, interrupt or nothing
// [R7] sleep hold pauses counting in deep sleep
// [R8] window mode when limit below reload value
// [R9] changing window limit reloads the counter
// [R10] early refresh in window mode resets system
// [R11] software refreshes inside window before zero
// [R12] unlock key opens config; other keys lock
// [R13] protected registers locked after reset
// [R14] stop key pair in order stops counter
// [R15] start, refresh and stop keys relock
// [R16] status shows running and overflow flags
// [R17] pending flags while register writes apply
// [R18] reload flag high while reload applies
// [R19] period is divider times reload plus one
// [R20] protected writes accepted only once started
// [R21] overflow flag sticky until written zero
// [R22] writes cross to oscillator edge, flags held
module iww_top (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// oscillator and power state
	input wire logic i_osc,
	input wire logic i_deep_sleep,
	// register port
	input wire iww_pkg::iww_bus_t i_bus,
	output logic [31:0] o_rdata,
	// system responses
	output logic o_sys_rst,
	output logic o_irq
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic osc_meta;
		logic osc_sync;
		logic osc_prev;
		logic [8:0] pres;
		logic [11:0] cnt;
		logic run;
		logic ov;
		iww_pkg::iww_cfg_t cfg_sw;
		iww_pkg::iww_cfg_t cfg_act;
		logic [11:0] arr_sw;
		logic [11:0] arr_act;
		logic [11:0] win_sw;
		logic [11:0] win_act;
		logic unlocked;
		logic stop_armed;
		logic pend_cfg;
		logic pend_arr;
		logic pend_win;
		logic pend_reload;
		logic pend_start;
		logic pend_stop;
		logic [31:0] rdata;
		logic sys_rst;
		logic irq;
	} iww_state_t;

	iww_state_t s_q;
	iww_state_t s_d;
	logic osc_edge;
	logic hold;
	logic early;
	logic tick;
	logic load;
	logic wr_ok;
	logic ov_set;
	logic ov_clr;
	logic [8:0] div_last;
	logic [15:0] key;

	assign key = i_bus.wdata[15:0];

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		tick = 1'b0;
		load = 1'b0;
		ov_set = 1'b0;
		ov_clr = 1'b0;
		// oscillator crosses in through two flops
		s_d.osc_meta = i_osc;
		s_d.osc_sync = s_q.osc_meta;
		s_d.osc_prev = s_q.osc_sync;
		osc_edge = s_q.osc_sync & ~s_q.osc_prev;
		// divider is 4 << code, last prescaler count
		div_last = 9'((iww_pkg::DIV_BASE <<
			s_q.cfg_act.divider_select) - 10'h001); // see [R2] [R19]
		hold = s_q.cfg_act.sleep_hold & i_deep_sleep; // see [R7]
		// window mode only while limit sits below reload
		early = (s_q.win_act < s_q.arr_act) &&
			(s_q.cnt > s_q.win_act); // see [R8] [R10]
		wr_ok = s_q.unlocked & s_q.run; // see [R20] [R12]
		s_d.sys_rst = 1'b0;
		s_d.rdata = 32'h0000_0000;
		// ----------------------------------------
		// oscillator-edge work
		// ----------------------------------------
		if (osc_edge) begin
			// pending writes take effect here
			if (s_q.pend_cfg) begin
				s_d.cfg_act = s_q.cfg_sw; // see [R22]
				s_d.pres = 9'h000;
				s_d.pend_cfg = 1'b0;
			end
			if (s_q.pend_arr) begin
				s_d.arr_act = s_q.arr_sw;
				s_d.pend_arr = 1'b0;
			end
			if (s_q.pend_win) begin
				s_d.win_act = s_q.win_sw;
				s_d.pend_win = 1'b0;
				if (s_q.win_sw != s_q.win_act) begin
					load = s_q.run; // see [R9]
				end
			end
			if (s_q.pend_reload) begin
				s_d.pend_reload = 1'b0; // see [R18]
				if (s_q.run && early) begin
					s_d.sys_rst = 1'b1; // see [R10]
				end else begin
					load = s_q.run; // see [R4]
				end
			end
			if (s_q.pend_stop) begin
				s_d.run = 1'b0; // see [R14]
				s_d.pend_stop = 1'b0;
			end
			if (s_q.pend_start) begin
				s_d.run = 1'b1; // see [R3]
				s_d.cnt = iww_pkg::CNT_START;
				s_d.pres = 9'h000;
				s_d.pend_start = 1'b0;
			end else if (load) begin
				s_d.cnt = s_d.arr_act;
				s_d.pres = 9'h000;
			end else if (s_q.run && !hold && !s_q.pend_stop &&
				!s_q.pend_cfg) begin
				if (s_q.pres >= div_last) begin
					s_d.pres = 9'h000;
					tick = 1'b1;
				end else begin
					s_d.pres = s_q.pres + 9'h001;
				end
			end
			// a tick at zero reloads and flags overflow
			if (tick) begin
				if (s_q.cnt == 12'h000) begin
					s_d.cnt = s_q.arr_act; // see [R5] [R19]
					ov_set = 1'b1;
					s_d.sys_rst = ~s_q.cfg_act.resp_sel; // see [R6]
				end else begin
					s_d.cnt = s_q.cnt - 12'h001; // see [R1]
				end
			end
		end
		// ----------------------------------------
		// register writes; sets follow clears
		// ----------------------------------------
		if (i_bus.wr) begin
			unique case (i_bus.addr)
				iww_pkg::OFS_KEY: begin
					// every key but unlock closes the registers
					s_d.unlocked = (key == iww_pkg::KEY_UNLOCK); // see [R12] [R15]
					s_d.stop_armed = (key == iww_pkg::KEY_STOP1);
					if (key == iww_pkg::KEY_START) begin
						s_d.pend_start = 1'b1;
					end
					if (key == iww_pkg::KEY_REFRESH) begin
						s_d.pend_reload = 1'b1; // see [R18]
					end
					if (key == iww_pkg::KEY_STOP2 && s_q.stop_armed) begin
						s_d.pend_stop = 1'b1; // see [R14]
					end
				end
				iww_pkg::OFS_CFG: begin
					// a write while still pending is dropped
					if (wr_ok && !s_q.pend_cfg) begin
						s_d.cfg_sw = i_bus.wdata[5:0];
						s_d.pend_cfg = 1'b1; // see [R17]
					end
				end
				iww_pkg::OFS_RLD: begin
					if (wr_ok && !s_q.pend_arr) begin
						s_d.arr_sw = i_bus.wdata[11:0];
						s_d.pend_arr = 1'b1; // see [R17]
					end
				end
				iww_pkg::OFS_WIN: begin
					if (wr_ok && !s_q.pend_win) begin
						s_d.win_sw = i_bus.wdata[11:0];
						s_d.pend_win = 1'b1; // see [R17]
					end
				end
				iww_pkg::OFS_STAT: begin
					ov_clr = ~i_bus.wdata[iww_pkg::ST_OV];
				end
				default: begin
				end
			endcase
		end
		// overflow set wins over a same-cycle clear
		s_d.ov = ov_set | (s_q.ov & ~ov_clr); // see [R21]
		s_d.irq = s_d.ov & s_q.cfg_act.resp_sel &
			s_q.cfg_act.irq_enable; // see [R6]
		// ----------------------------------------
		// register reads
		// ----------------------------------------
		if (i_bus.rd) begin
			unique case (i_bus.addr)
				iww_pkg::OFS_CFG: begin
					s_d.rdata = {26'h000_0000, s_q.cfg_sw};
				end
				iww_pkg::OFS_RLD: begin
					s_d.rdata = {20'h0_0000, s_q.arr_sw};
				end
				iww_pkg::OFS_WIN: begin
					s_d.rdata = {20'h0_0000, s_q.win_sw};
				end
				iww_pkg::OFS_CNT: begin
					s_d.rdata = {20'h0_0000, s_q.cnt};
				end
				iww_pkg::OFS_STAT: begin
					s_d.rdata = {26'h000_0000, s_q.pend_reload,
						s_q.run, s_q.ov, s_q.pend_win,
						s_q.pend_arr, s_q.pend_cfg}; // see [R16] [R17]
				end
				default: begin
					s_d.rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s_q <= '0;
			s_q.cnt <= iww_pkg::CNT_START;
			s_q.cfg_sw <= iww_pkg::CFG_RST;
			s_q.cfg_act <= iww_pkg::CFG_RST;
			s_q.arr_sw <= iww_pkg::RLD_RST;
			s_q.arr_act <= iww_pkg::RLD_RST;
			s_q.win_sw <= iww_pkg::WIN_RST; // see [R8]
			s_q.win_act <= iww_pkg::WIN_RST;
			s_q.unlocked <= 1'b0; // see [R13]
		end else begin
			s_q <= s_d;
		end
	end

	assign o_rdata = s_q.rdata;
	assign o_sys_rst = s_q.sys_rst;
	assign o_irq = s_q.irq;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sequence s_wrap;
		tick && s_q.cnt == 12'h000;
	endsequence
	sequence s_key(logic [15:0] k);
		i_bus.wr && i_bus.addr == iww_pkg::OFS_KEY && key == k;
	endsequence

	property p_step;
		(tick && s_q.cnt != 12'h000) |=>
			s_q.cnt == $past(s_q.cnt) - 12'h001;
	endproperty
	a_step: assert property (p_step) // see [R1]
		else $error("counter did not step down by one");

	property p_div;
		s_q.run |-> s_q.pres <= div_last;
	endproperty
	a_div: assert property (p_div) // see [R2]
		else $error("prescaler ran past divider");

	property p_start;
		(osc_edge && s_q.pend_start) |=>
			s_q.run && s_q.cnt == iww_pkg::CNT_START;
	endproperty
	a_start: assert property (p_start) // see [R3]
		else $error("start did not load FFF");

	property p_wrap;
		s_wrap |=> s_q.ov && s_q.cnt == $past(s_q.arr_act);
	endproperty
	a_wrap: assert property (p_wrap) // see [R5]
		else $error("overflow did not flag and reload");

	property p_resp;
		(s_wrap and !s_q.cfg_act.resp_sel) |=> o_sys_rst;
	endproperty
	a_resp: assert property (p_resp) // see [R6]
		else $error("overflow reset missing");

	property p_irq;
		(s_q.ov && s_q.cfg_act.resp_sel && s_q.cfg_act.irq_enable &&
			$stable(s_q.cfg_act) &&
			!(i_bus.wr && i_bus.addr == iww_pkg::OFS_STAT &&
			!i_bus.wdata[iww_pkg::ST_OV])) |=> o_irq;
	endproperty
	a_irq: assert property (p_irq) // see [R6]
		else $error("interrupt missing");

	property p_early;
		(osc_edge && s_q.pend_reload && s_q.run &&
			s_q.win_act < s_q.arr_act && s_q.cnt > s_q.win_act)
			|=> o_sys_rst;
	endproperty
	a_early: assert property (p_early) // see [R10]
		else $error("early refresh did not reset");

	property p_hold;
		(osc_edge && hold && s_q.run && !s_q.pend_reload &&
			!s_q.pend_start && !s_q.pend_win) |=> $stable(s_q.cnt);
	endproperty
	a_hold: assert property (p_hold) // see [R7]
		else $error("counter moved during held sleep");

	property p_lock;
		(i_bus.wr && i_bus.addr == iww_pkg::OFS_CFG && !s_q.unlocked)
			|=> $stable(s_q.cfg_sw);
	endproperty
	a_lock: assert property (p_lock) // see [R12]
		else $error("locked config was written");

	property p_stop;
		// a non-key cycle between the pair must not disarm it
		s_key(iww_pkg::KEY_STOP1) ##1
			!(i_bus.wr && i_bus.addr == iww_pkg::OFS_KEY) ##1
			s_key(iww_pkg::KEY_STOP2) |=> s_q.pend_stop;
	endproperty
	a_stop: assert property (p_stop) // see [R14]
		else $error("stop pair not taken");

	property p_relock;
		s_key(iww_pkg::KEY_START) |=> !s_q.unlocked;
	endproperty
	a_relock: assert property (p_relock) // see [R15]
		else $error("start key did not relock");

	property p_ov_hold;
		(s_q.ov && !(i_bus.wr && i_bus.addr == iww_pkg::OFS_STAT))
			|=> s_q.ov;
	endproperty
	a_ov_hold: assert property (p_ov_hold) // see [R21]
		else $error("overflow flag dropped on its own");

	property p_pend;
		(s_q.pend_win && !osc_edge) |=> s_q.pend_win;
	endproperty
	a_pend: assert property (p_pend) // see [R22] [R17]
		else $error("window pending cleared early");

	property p_stat;
		(i_bus.rd && i_bus.addr == iww_pkg::OFS_STAT) |=>
			o_rdata[iww_pkg::ST_RUN] == $past(s_q.run) &&
			o_rdata[iww_pkg::ST_RELOAD] == $past(s_q.pend_reload);
	endproperty
	a_stat: assert property (p_stat) // see [R16] [R18]
		else $error("status read wrong");
endmodule // iww_top

// ==== sim/tb_iww_top.sv ====
// self-checking bench for the window watchdog over its register port
// assumes iww_pkg and iww_top compiled first; the bench makes the oscillator
`timescale 1ns/1ns
module tb_iww_top;
	logic i_clk;
	logic i_rst = 1'b1;
	logic i_osc;
	logic i_deep_sleep = 1'b0;
	iww_pkg::iww_bus_t i_bus = '0;
	logic [31:0] o_rdata;
	logic o_sys_rst;
	logic o_irq;
	logic [31:0] d;
	int error_cnt = 0;
	int tests_run = 0;
	int cyc = 0;
	int rst_seen = 0;
	int rst_t = 0;
	int t0;
	int i;

	iww_top iww_top_inst (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_osc(i_osc),
		.i_deep_sleep(i_deep_sleep),
		.i_bus(i_bus),
		.o_rdata(o_rdata),
		.o_sys_rst(o_sys_rst),
		.o_irq(o_irq)
	);

	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	// oscillator far faster than real so the run stays short;
	// its edges are kept off the clock edges
	initial begin
		i_osc = 1'b0;
		#25;
		forever #800 i_osc = ~i_osc;
	end

	// reset pulses are one cycle wide, so count them here
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (o_sys_rst === 1'b1) begin
			rst_seen <= rst_seen + 1;
			rst_t <= cyc;
		end
		if (cyc == 90000) begin
			error_cnt++;
			wrap_up;
		end
	end

	// ----------------------------------------
	// register port tasks
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge i_clk);
		i_bus.addr <= a;
		i_bus.wdata <= v;
		i_bus.wr <= 1'b1;
		@(posedge i_clk);
		i_bus.wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge i_clk);
		i_bus.addr <= a;
		i_bus.rd <= 1'b1;
		@(posedge i_clk);
		i_bus.rd <= 1'b0;
		#1 d = o_rdata;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] m, e);
		rd(a);
		chk(d & m, e);
	endtask

	task automatic poll(input logic [7:0] a, input logic [31:0] m, v);
		for (int k = 0; k < 300; k++) begin
			rd(a);
			if ((d & m) === v) break;
		end
		chk(d & m, v);
	endtask

	// pending and reload flags must all drop
	task automatic settle;
		poll(iww_pkg::OFS_STAT, 32'h27, 32'h0);
	endtask

	task automatic key(input logic [15:0] k);
		wr(iww_pkg::OFS_KEY, {16'h0, k});
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge i_clk);
	endtask

	task automatic wait_rst(input int lim);
		int n;
		n = rst_seen;
		for (int k = 0; k < lim && rst_seen == n; k++) @(posedge i_clk);
		chk(rst_seen - n, 1);
	endtask

	// counter compared across 300 cycles, well over one tick
	task automatic moved(input logic [31:0] e);
		logic [31:0] c;
		rd(iww_pkg::OFS_CNT);
		c = d;
		idle(300);
		rd(iww_pkg::OFS_CNT);
		chk(d != c, e);
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		idle(10);
		i_rst <= 1'b0;
		wr(8'h30, 32'hffff);
		rchk(iww_pkg::OFS_STAT, '1, 32'h0);
		rchk(iww_pkg::OFS_CFG, '1, 32'h0);
		rchk(iww_pkg::OFS_RLD, '1, 32'hfff);
		rchk(iww_pkg::OFS_WIN, '1, 32'hfff);
		rchk(iww_pkg::OFS_CNT, '1, 32'hfff);
		rchk(iww_pkg::OFS_KEY, '1, 32'h0);
		rchk(8'h30, '1, 32'h0);
		key(iww_pkg::KEY_UNLOCK);
		wr(iww_pkg::OFS_RLD, 32'h5);
		idle(40);
		rchk(iww_pkg::OFS_RLD, '1, 32'hfff);
		key(iww_pkg::KEY_START);
		poll(iww_pkg::OFS_STAT, 32'h10, 32'h10);
		rchk(iww_pkg::OFS_CNT, '1, 32'hfff);
		key(iww_pkg::KEY_UNLOCK);
		key(16'h1234);
		wr(iww_pkg::OFS_RLD, 32'h7);
		wr(iww_pkg::OFS_CFG, 32'h3f);
		idle(40);
		rchk(iww_pkg::OFS_RLD, '1, 32'hfff);
		rchk(iww_pkg::OFS_CFG, '1, 32'h0);
		// writes land well before the next synchronised oscillator edge
		key(iww_pkg::KEY_UNLOCK);
		@(negedge i_osc);
		wr(iww_pkg::OFS_CFG, 32'h18);
		wr(iww_pkg::OFS_RLD, 32'h5);
		rchk(iww_pkg::OFS_STAT, 32'h7, 32'h3);
		settle;
		rchk(iww_pkg::OFS_CFG, '1, 32'h18);
		rchk(iww_pkg::OFS_RLD, '1, 32'h5);
		@(negedge i_osc);
		key(iww_pkg::KEY_REFRESH);
		rchk(iww_pkg::OFS_STAT, 32'h20, 32'h20);
		settle;
		rchk(iww_pkg::OFS_CNT, '1, 32'h5);
		wr(iww_pkg::OFS_RLD, 32'h7);
		idle(40);
		rchk(iww_pkg::OFS_RLD, '1, 32'h5);
		for (i = 0; i < 500 && o_irq !== 1'b1; i++) idle(1);
		chk(o_irq, 1);
		rchk(iww_pkg::OFS_STAT, 32'h8, 32'h8);
		rchk(iww_pkg::OFS_CNT, '1, 32'h5);
		chk(rst_seen, 0);
		wr(iww_pkg::OFS_STAT, 32'h8);
		rchk(iww_pkg::OFS_STAT, 32'h8, 32'h8);
		wr(iww_pkg::OFS_STAT, 32'h0);
		rchk(iww_pkg::OFS_STAT, 32'h8, 32'h0);
		chk(o_irq, 0);
		key(iww_pkg::KEY_UNLOCK);
		wr(iww_pkg::OFS_CFG, 32'h8);
		settle;
		idle(450);
		rchk(iww_pkg::OFS_STAT, 32'h8, 32'h8);
		chk(o_irq, 0);
		chk(rst_seen, 0);
		key(iww_pkg::KEY_UNLOCK);
		wr(iww_pkg::OFS_CFG, 32'h28);
		settle;
		@(posedge i_clk);
		i_deep_sleep <= 1'b1;
		moved(0);
		@(posedge i_clk);
		i_deep_sleep <= 1'b0;
		moved(1);
		key(iww_pkg::KEY_UNLOCK);
		wr(iww_pkg::OFS_CFG, 32'h8);
		settle;
		@(posedge i_clk);
		i_deep_sleep <= 1'b1;
		moved(1);
		@(posedge i_clk);
		i_deep_sleep <= 1'b0;
		// window of 3 under a reload of 5, reset on overflow
		key(iww_pkg::KEY_UNLOCK);
		wr(iww_pkg::OFS_CFG, 32'h0);
		wr(iww_pkg::OFS_WIN, 32'h3);
		settle;
		rchk(iww_pkg::OFS_CNT, 32'hffe, 32'h4);
		t0 = rst_seen;
		key(iww_pkg::KEY_REFRESH);
		idle(40);
		chk(rst_seen - t0, 1);
		t0 = rst_seen;
		poll(iww_pkg::OFS_CNT, 32'hffc, 32'h0);
		key(iww_pkg::KEY_REFRESH);
		poll(iww_pkg::OFS_STAT, 32'h20, 32'h0);
		chk(rst_seen - t0, 0);
		rchk(iww_pkg::OFS_CNT, '1, 32'h5);
		// shortest reload, so each tick overflows
		key(iww_pkg::KEY_UNLOCK);
		wr(iww_pkg::OFS_WIN, 32'hfff);
		wr(iww_pkg::OFS_RLD, 32'h0);
		settle;
		for (i = 0; i < 8; i++) begin
			key(iww_pkg::KEY_UNLOCK);
			wr(iww_pkg::OFS_CFG, i);
			settle;
			wait_rst(130 << i);
			t0 = rst_t;
			wait_rst(130 << i);
			chk(rst_t - t0, 64 << i);
		end
		key(iww_pkg::KEY_UNLOCK);
		wr(iww_pkg::OFS_CFG, 32'h0);
		settle;
		key(iww_pkg::KEY_STOP1);
		key(iww_pkg::KEY_REFRESH);
		key(iww_pkg::KEY_STOP2);
		idle(40);
		rchk(iww_pkg::OFS_STAT, 32'h10, 32'h10);
		key(iww_pkg::KEY_STOP1);
		key(iww_pkg::KEY_STOP2);
		poll(iww_pkg::OFS_STAT, 32'h10, 32'h0);
		moved(0);
		wrap_up;
	end
endmodule // tb_iww_top
